// File: src/usr_regs.svh
// register offsets, field positions, reset values and sizes of the shift/storage block
// assumes a 4-bit byte address on the register port, word-aligned registers
//
// Notes on behaviour
// - two select inputs pick hold, right, left, load
// - shift right moves toward last, right input enters
// - shift left moves toward first, left input enters
// - load captures parallel terminals on clock edge
// - load mode forces parallel drivers off
// - enabled drivers show stored word otherwise
// - clear low zeroes stages and serial outputs
// - either output control high disables drivers
// - drivers off never change stored data
// - eight stages, one shared bidirectional port
`ifndef USR_REGS_SVH
`define USR_REGS_SVH

`define USR_WIDTH 8
`define USR_FIFO_DEPTH 16
`define USR_PIN_COUNT 16

`define USR_ADDR_CTRL 4'h0
`define USR_ADDR_STATUS 4'h4
`define USR_ADDR_FIFO 4'h8
`define USR_ADDR_LEVEL 4'hc

`define USR_CTRL_CAPTURE 0
`define USR_CTRL_STALL 1
`define USR_CTRL_SOFT_CLR 2

`define USR_STAT_MODE_LO 8
`define USR_STAT_MODE_HI 9
`define USR_STAT_OE 10
`define USR_STAT_EMPTY 11
`define USR_STAT_FULL 12
`define USR_STAT_OVERRUN 13
`define USR_STAT_PEND 14

`define USR_FIFO_VALID 8

`define USR_CAPTURE_RESET 1'b0
`define USR_STALL_RESET 1'b0
`define USR_DATA_RESET 8'h00
`define USR_OE_ON 8'hff
`define USR_OE_OFF 8'h00
`define USR_WORD_ZERO 32'h0000_0000

`endif

// File: src/usr_pkg.sv
// types shared by the shift/storage block
// assumes usr_regs.svh is included first
`include "usr_regs.svh"

package usr_pkg;

    typedef enum logic [1:0] {
        mode_hold = 2'b00,
        mode_shift_right = 2'b01,
        mode_shift_left = 2'b10,
        mode_load = 2'b11
    } usr_mode_t;

    typedef struct packed {
        logic [`USR_WIDTH-1:0] data;
        logic [`USR_WIDTH-1:0] par_oe;
        logic dclk_prev;
        logic edge_pend;
        logic capture_en;
        logic stall_on_full;
        logic overrun;
        logic [31:0] rdata;
    } usr_state_t;

endpackage : usr_pkg

// File: src/usr_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes each bit is an independent level
`timescale 1ns/10ps
`default_nettype none

module usr_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins and their synchronised copy
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } usr_sync_state_t;

    usr_sync_state_t st_reg;
    usr_sync_state_t st_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("usr_sync: WIDTH must be at least 1");
    end

    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.s2;

endmodule : usr_sync

`default_nettype wire

// File: src/usr_fifo.sv
// flop-based FIFO with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/10ps
`default_nettype none

module usr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    localparam int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // occupancy
    output logic [AW:0] level
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } usr_fifo_state_t;

    usr_fifo_state_t st_reg;
    usr_fifo_state_t st_next;
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_shape
        $error("usr_fifo: DEPTH must be a power of two above one");
    end

    assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data = st_reg.mem[st_reg.rd_ptr];
    assign level = st_reg.count;

    always_comb begin
        st_next = st_reg;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data;
            st_next.wr_ptr = st_reg.wr_ptr + AW'(1);
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + (AW+1)'(1);
        end else if (pop && !push) begin
            st_next.count = st_reg.count - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : usr_fifo

`default_nettype wire

// File: src/usr_shift_storage.sv
// eight-stage universal shift/storage register with shared parallel port
// assumes all device pins are asynchronous to clk_sys, the device clock
// is a pin sampled and edge-detected in the clk_sys domain, and the bench
// resolves the parallel wire from parallel_io_out and parallel_io_oe
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "usr_regs.svh"

module usr_shift_storage #(
    parameter int FIFO_DEPTH = `USR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,

    // device clock and clear pins
    input wire logic dev_clk,
    input wire logic clear_n,

    // mode and output-control pins
    input wire logic func_sel_high,
    input wire logic func_sel_low,
    input wire logic out_ctl_a_n,
    input wire logic out_ctl_b_n,

    // serial inputs
    input wire logic left_serial_in,
    input wire logic right_serial_in,

    // shared parallel port, bit 0 is the first stage
    input wire logic [`USR_WIDTH-1:0] parallel_io_in,
    output logic [`USR_WIDTH-1:0] parallel_io_out,
    output logic [`USR_WIDTH-1:0] parallel_io_oe,

    // serial end-bit outputs
    output logic first_stage_serial_out,
    output logic last_stage_serial_out,

    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    localparam usr_pkg::usr_state_t ST_RESET = '{
        data: `USR_DATA_RESET,
        par_oe: `USR_OE_OFF,
        dclk_prev: 1'b0,
        edge_pend: 1'b0,
        capture_en: `USR_CAPTURE_RESET,
        stall_on_full: `USR_STALL_RESET,
        overrun: 1'b0,
        rdata: `USR_WORD_ZERO
    };

    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 1024) begin : g_bad_depth
        $error("usr_shift_storage: FIFO_DEPTH out of range");
    end

    // widen a byte-wide field into a bus word
    function automatic logic [31:0] usr_word(input logic [`USR_WIDTH-1:0] b);
        usr_word = {{(32-`USR_WIDTH){1'b0}}, b};
    endfunction : usr_word

    // one stage move for the selected mode
    function automatic logic [`USR_WIDTH-1:0] usr_step(
        input usr_pkg::usr_mode_t m,
        input logic [`USR_WIDTH-1:0] q,
        input logic [`USR_WIDTH-1:0] par,
        input logic sl,
        input logic sr
    );
        unique case (m)
            usr_pkg::mode_hold: usr_step = q;
            usr_pkg::mode_shift_right: usr_step = {q[`USR_WIDTH-2:0], sr};
            usr_pkg::mode_shift_left: usr_step = {sl, q[`USR_WIDTH-1:1]};
            usr_pkg::mode_load: usr_step = par;
        endcase
    endfunction : usr_step

    usr_pkg::usr_state_t st_reg;
    usr_pkg::usr_state_t st_next;

    // synchronised pins
    logic [`USR_PIN_COUNT-1:0] pins_raw;
    logic [`USR_PIN_COUNT-1:0] pins_sync;
    logic pin_dclk;
    logic pin_clear_n;
    logic pin_sel_high;
    logic pin_sel_low;
    logic pin_ctl_a_n;
    logic pin_ctl_b_n;
    logic pin_sl;
    logic pin_sr;
    logic [`USR_WIDTH-1:0] pin_par;

    // decoded control
    usr_pkg::usr_mode_t mode;
    logic dclk_rise;
    logic stall;
    logic fire;
    logic soft_clr;
    logic wr_ctrl;
    logic wr_status;
    logic fifo_read;
    logic overrun_set;
    logic [`USR_WIDTH-1:0] data_new;

    // FIFO wiring
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`USR_WIDTH-1:0] fifo_out_data;
    logic [LW-1:0] fifo_level;

    assign pins_raw = {
        dev_clk,
        clear_n,
        func_sel_high,
        func_sel_low,
        out_ctl_a_n,
        out_ctl_b_n,
        left_serial_in,
        right_serial_in,
        parallel_io_in
    };

    usr_sync #(
        .WIDTH(`USR_PIN_COUNT)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    assign {
        pin_dclk,
        pin_clear_n,
        pin_sel_high,
        pin_sel_low,
        pin_ctl_a_n,
        pin_ctl_b_n,
        pin_sl,
        pin_sr,
        pin_par
    } = pins_sync;

    usr_fifo #(
        .WIDTH(`USR_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(data_new),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // control decode
    always_comb begin
        mode = usr_pkg::usr_mode_t'({pin_sel_high, pin_sel_low});
        dclk_rise = pin_dclk && !st_reg.dclk_prev;
        stall = st_reg.stall_on_full && st_reg.capture_en && !fifo_in_ready;
        fire = (dclk_rise || st_reg.edge_pend) && !stall && pin_clear_n;
        wr_ctrl = reg_wr && (reg_addr == `USR_ADDR_CTRL);
        wr_status = reg_wr && (reg_addr == `USR_ADDR_STATUS);
        soft_clr = wr_ctrl && reg_wdata[`USR_CTRL_SOFT_CLR];
        fifo_read = reg_rd && (reg_addr == `USR_ADDR_FIFO);
        fifo_out_ready = fifo_read;
        data_new = usr_step(mode, st_reg.data, pin_par, pin_sl, pin_sr);
        fifo_in_valid = fire && st_reg.capture_en && !soft_clr;
        overrun_set = (fifo_in_valid && !fifo_in_ready)
            || (dclk_rise && st_reg.edge_pend && stall);
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.dclk_prev = pin_dclk;

        // stage update; drivers never gate this path
        if (!pin_clear_n || soft_clr) begin
            st_next.data = `USR_DATA_RESET;
            st_next.edge_pend = 1'b0;
        end else if (fire) begin
            st_next.data = data_new;
            st_next.edge_pend = dclk_rise && st_reg.edge_pend;
        end else if (dclk_rise) begin
            // edge held back while stall-on-full and capture are set and the FIFO is full
            st_next.edge_pend = 1'b1;
        end

        // parallel drivers
        if (mode == usr_pkg::mode_load) begin
            st_next.par_oe = `USR_OE_OFF;
        end else if (pin_ctl_a_n || pin_ctl_b_n) begin
            st_next.par_oe = `USR_OE_OFF;
        end else begin
            st_next.par_oe = `USR_OE_ON;
        end

        // control writes
        if (wr_ctrl) begin
            st_next.capture_en = reg_wdata[`USR_CTRL_CAPTURE];
            st_next.stall_on_full = reg_wdata[`USR_CTRL_STALL];
        end

        // sticky overrun, set wins over write-one-clear
        if (overrun_set) begin
            st_next.overrun = 1'b1;
        end else if (wr_status && reg_wdata[`USR_STAT_OVERRUN]) begin
            st_next.overrun = 1'b0;
        end

        // read data stands one cycle only
        st_next.rdata = `USR_WORD_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                `USR_ADDR_CTRL: begin
                    st_next.rdata[`USR_CTRL_CAPTURE] = st_reg.capture_en;
                    st_next.rdata[`USR_CTRL_STALL] = st_reg.stall_on_full;
                end
                `USR_ADDR_STATUS: begin
                    st_next.rdata = usr_word(st_reg.data);
                    st_next.rdata[`USR_STAT_MODE_HI:`USR_STAT_MODE_LO] = mode;
                    st_next.rdata[`USR_STAT_OE] = st_reg.par_oe[0];
                    st_next.rdata[`USR_STAT_EMPTY] = !fifo_out_valid;
                    st_next.rdata[`USR_STAT_FULL] = !fifo_in_ready;
                    st_next.rdata[`USR_STAT_OVERRUN] = st_reg.overrun;
                    st_next.rdata[`USR_STAT_PEND] = st_reg.edge_pend;
                end
                `USR_ADDR_FIFO: begin
                    if (fifo_out_valid) begin
                        st_next.rdata = usr_word(fifo_out_data);
                        st_next.rdata[`USR_FIFO_VALID] = 1'b1;
                    end
                end
                `USR_ADDR_LEVEL: begin
                    st_next.rdata = 32'(fifo_level);
                end
                default: begin
                    st_next.rdata = `USR_WORD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state flops
    assign parallel_io_out = st_reg.data;
    assign parallel_io_oe = st_reg.par_oe;
    assign first_stage_serial_out = st_reg.data[0];
    assign last_stage_serial_out = st_reg.data[`USR_WIDTH-1];
    assign reg_rdata = st_reg.rdata;

endmodule : usr_shift_storage

`default_nettype wire

// File: tb/usr_shift_storage_asserts.sv
// port checker of the shift/storage block
// assumes pins stay steady around each device clock rise, stall set only while holding
`timescale 1ns/10ps
`default_nettype none
`include "usr_regs.svh"
module usr_shift_storage_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // device pins
    input wire logic dev_clk,
    input wire logic clear_n,
    input wire logic func_sel_high,
    input wire logic func_sel_low,
    input wire logic out_ctl_a_n,
    input wire logic out_ctl_b_n,
    input wire logic left_serial_in,
    input wire logic right_serial_in,
    input wire logic [`USR_WIDTH-1:0] parallel_io_in,
    // device outputs
    input wire logic [`USR_WIDTH-1:0] parallel_io_out,
    input wire logic [`USR_WIDTH-1:0] parallel_io_oe,
    input wire logic first_stage_serial_out,
    input wire logic last_stage_serial_out
);
    logic [2:0] warm_reg;
    logic [2:0] warm_next;
    // pipeline of three cycles must refill after reset
    always_comb warm_next = (warm_reg == 3'h7) ? warm_reg : warm_reg + 3'h1;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            warm_reg <= 3'h0;
        end else begin
            warm_reg <= warm_next;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence edge_s(logic [1:0] m);
        warm_reg == 3'h7 && $rose(dev_clk) && clear_n && {func_sel_high, func_sel_low} == m;
    endsequence
    sequence settle_s;
        ##3 1'b1;
    endsequence
    hold_keep_a: assert property (edge_s(2'b00) |-> settle_s ##0 $stable(parallel_io_out))
        else $error("stored word moved in hold");
    shift_right_a: assert property (edge_s(2'b01) |-> settle_s ##0
        parallel_io_out == {$past(parallel_io_out[6:0]), $past(right_serial_in, 3)})
        else $error("shift right result wrong");
    shift_left_a: assert property (edge_s(2'b10) |-> settle_s ##0
        parallel_io_out == {$past(left_serial_in, 3), $past(parallel_io_out[7:1])})
        else $error("shift left result wrong");
    load_capture_a: assert property (edge_s(2'b11) |-> settle_s ##0
        parallel_io_out == $past(parallel_io_in, 3))
        else $error("load result wrong");
    clear_zero_a: assert property (warm_reg == 3'h7 && !$past(clear_n, 3) |->
        parallel_io_out == `USR_DATA_RESET && !first_stage_serial_out && !last_stage_serial_out)
        else $error("clear did not zero the stages");
    oe_follow_a: assert property (warm_reg == 3'h7 |-> parallel_io_oe ==
        ((!$past(func_sel_high, 3) || !$past(func_sel_low, 3)) && !$past(out_ctl_a_n, 3)
        && !$past(out_ctl_b_n, 3) ? `USR_OE_ON : `USR_OE_OFF))
        else $error("drive enable wrong");
    oe_uniform_a: assert property (parallel_io_oe == `USR_OE_ON ||
        parallel_io_oe == `USR_OE_OFF) else $error("drive enables differ");
    serial_ends_a: assert property (first_stage_serial_out == parallel_io_out[0] &&
        last_stage_serial_out == parallel_io_out[7]) else $error("serial ends wrong");
endmodule : usr_shift_storage_asserts
bind usr_shift_storage usr_shift_storage_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .dev_clk(dev_clk), .clear_n(clear_n), .func_sel_high(func_sel_high),
    .func_sel_low(func_sel_low), .out_ctl_a_n(out_ctl_a_n), .out_ctl_b_n(out_ctl_b_n),
    .left_serial_in(left_serial_in), .right_serial_in(right_serial_in),
    .parallel_io_in(parallel_io_in), .parallel_io_out(parallel_io_out),
    .parallel_io_oe(parallel_io_oe), .first_stage_serial_out(first_stage_serial_out),
    .last_stage_serial_out(last_stage_serial_out));
`default_nettype wire

// File: tb/usr_far_side.sv
// bus logic at the far side of the shared parallel port
// assumes the bench asks for drive only when a load is wanted
`timescale 1ns/10ps
`default_nettype none
`include "usr_regs.svh"
module usr_far_side (
    // clock
    input wire logic clk_sys,
    // device side of the port
    input wire logic [`USR_WIDTH-1:0] dev_out,
    input wire logic [`USR_WIDTH-1:0] dev_oe,
    // load data
    input wire logic drive_en,
    input wire logic [`USR_WIDTH-1:0] drive_val,
    // resolved wire level
    output logic [`USR_WIDTH-1:0] wire_val
);
    logic [`USR_WIDTH-1:0] last_reg = '0;
    // remember the last level someone drove
    always_ff @(posedge clk_sys) begin
        if (dev_oe != `USR_OE_OFF || drive_en) begin
            last_reg <= wire_val;
        end
    end
    // device wins; a floating pin shows the inverse of its last driven level
    always_comb begin
        for (int i = 0; i < `USR_WIDTH; i++) begin
            if (dev_oe[i]) begin
                wire_val[i] = dev_out[i];
            end else if (drive_en) begin
                wire_val[i] = drive_val[i];
            end else begin
                wire_val[i] = ~last_reg[i];
            end
        end
    end
endmodule : usr_far_side
`default_nettype wire

// File: tb/test_usr_shift_storage.sv
// self-checking bench of the shift/storage block
// assumes usr_far_side and the bound checker are compiled beside it
`timescale 1ns/10ps
`default_nettype none
`include "usr_regs.svh"
`define CHK(g, e) begin \
    checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module test_usr_shift_storage;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic dev_clk = 1'b0;
    logic clear_n = 1'b1;
    logic [1:0] sel = 2'b00;
    logic ga_n = 1'b0;
    logic gb_n = 1'b0;
    logic sl = 1'b0;
    logic sr = 1'b0;
    logic drive_en = 1'b0;
    logic [7:0] drive_val = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] par_wire;
    logic [7:0] par_out;
    logic [7:0] par_oe;
    logic q_first;
    logic q_last;
    logic [31:0] reg_rdata;
    logic [7:0] exp_q = 8'h00;
    logic [7:0] exp_oe;
    logic [7:0] words [16];
    int error_cnt = 0;
    int checks = 0;
    always #5 clk_sys = ~clk_sys;
    usr_shift_storage #(.FIFO_DEPTH(16)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .dev_clk(dev_clk), .clear_n(clear_n), .func_sel_high(sel[1]), .func_sel_low(sel[0]),
        .out_ctl_a_n(ga_n), .out_ctl_b_n(gb_n), .left_serial_in(sl), .right_serial_in(sr),
        .parallel_io_in(par_wire), .parallel_io_out(par_out), .parallel_io_oe(par_oe),
        .first_stage_serial_out(q_first), .last_stage_serial_out(q_last),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    usr_far_side far (.clk_sys(clk_sys), .dev_out(par_out), .dev_oe(par_oe),
        .drive_en(drive_en), .drive_val(drive_val), .wire_val(par_wire));
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] mask);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata & mask, e)
    endtask : rd
    // one device clock pulse with modes and pins held around it
    task automatic step(input logic [1:0] m, input logic l, input logic r,
        input logic [7:0] d, input logic a, input logic b);
        @(posedge clk_sys);
        sel <= m;
        sl <= l;
        sr <= r;
        drive_en <= (m == 2'b11);
        drive_val <= d;
        ga_n <= a;
        gb_n <= b;
        repeat (4) @(posedge clk_sys);
        dev_clk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        dev_clk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        if (!clear_n) begin
            exp_q = 8'h00;
        end else begin
            case (m)
                2'b01: exp_q = {exp_q[6:0], r};
                2'b10: exp_q = {l, exp_q[7:1]};
                2'b11: exp_q = d;
                default: exp_q = exp_q;
            endcase
        end
        exp_oe = (m != 2'b11 && !a && !b) ? 8'hff : 8'h00;
        `CHK(par_out, exp_q)
        `CHK({q_last, q_first}, {exp_q[7], exp_q[0]})
        `CHK(par_oe, exp_oe)
        if (exp_oe == 8'hff) `CHK(par_wire, exp_q)
    endtask : step
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(`USR_ADDR_STATUS, 32'h0000_0c00, 32'hffff_ffff);
        rd(4'h6, 32'h0000_0000, 32'hffff_ffff);
        for (int i = 0; i < 12; i++) begin
            step(i[1:0], i[2], i[0] ^ i[3], 8'h5a ^ i[7:0], i == 5, i == 9 || i == 10);
        end
        @(posedge clk_sys);
        clear_n <= 1'b0;
        step(2'b01, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0);
        @(posedge clk_sys);
        clear_n <= 1'b1;
        step(2'b00, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0);
        step(2'b11, 1'b0, 1'b0, 8'h96, 1'b0, 1'b0);
        step(2'b01, 1'b0, q_last, 8'h00, 1'b0, 1'b0);
        step(2'b10, q_first, 1'b0, 8'h00, 1'b0, 1'b0);
        wr(`USR_ADDR_CTRL, 32'h0000_0001);
        for (int i = 0; i < 17; i++) begin
            step(2'b01, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
            if (i < 16) words[i] = exp_q;
        end
        rd(`USR_ADDR_STATUS, 32'h0000_3000, 32'h0000_3800);
        rd(`USR_ADDR_LEVEL, 32'h0000_0010, 32'hffff_ffff);
        for (int i = 0; i < 16; i++) begin
            rd(`USR_ADDR_FIFO, {23'h0, 1'b1, words[i]}, 32'hffff_ffff);
        end
        rd(`USR_ADDR_FIFO, 32'h0000_0000, 32'h0000_0100);
        rd(`USR_ADDR_LEVEL, 32'h0000_0000, 32'hffff_ffff);
        wr(`USR_ADDR_STATUS, 32'h0000_2000);
        rd(`USR_ADDR_STATUS, 32'h0000_0800, 32'h0000_2800);
        // stall on full: held edge, then a lost one
        wr(`USR_ADDR_CTRL, 32'h0000_0003);
        for (int i = 0; i < 18; i++) begin
            step(2'b00, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
        end
        rd(`USR_ADDR_STATUS, 32'h0000_7000, 32'h0000_7800);
        rd(`USR_ADDR_FIFO, {23'h0, 1'b1, exp_q}, 32'hffff_ffff);
        rd(`USR_ADDR_LEVEL, 32'h0000_0010, 32'hffff_ffff);
        rd(`USR_ADDR_STATUS, 32'h0000_1000, 32'h0000_5000);
        // soft clear zeroes the stages
        wr(`USR_ADDR_CTRL, 32'h0000_0004);
        exp_q = 8'h00;
        rd(`USR_ADDR_STATUS, {24'h0, exp_q}, 32'h0000_00ff);
        end_sim();
    end
endmodule : test_usr_shift_storage
`default_nettype wire
